/* File: rtl/battery_thermal_runaway_monitor.sv */
// Sensor unit runaway detection plus summary relay combining logic
`timescale 1ns/1ps
`default_nettype none
module battery_thermal_runaway_monitor
	import runaway_pkg::*;
#(
	parameter int NCH = 5,
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int DEB_CYCLES = DEBOUNCE_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC
) (
	input wire logic clk,                       // 25 MHz clock
	input wire logic rst_b,                     // Async reset, active low
	input wire logic [NCH*TEMP_W-1:0] chan_temp, // Channel samples, signed
	input wire logic [TEMP_W-1:0] amb_temp,     // Ambient sample, signed
	input wire logic [NCH-1:0] probe_present,   // From converter
	input wire logic reset_btn,                 // Pin, high when pressed
	input wire logic [MAX_UNITS-1:0] chain_err, // Error lines of chained units
	output logic [NCH-1:0] channel_indicators,  // Per-channel LEDs
	output logic buzzer,                        // Audible alarm, this unit
	output logic err_out,                       // This unit's error line
	output logic summary_overheat_indicator,    // Summary unit LED
	output logic summary_contact                // Normally open contact closed
);
	logic btn_m_ff, btn_s_ff;
	logic [MAX_UNITS-1:0] err_m_ff, err_s_ff;
	logic [NCH-1:0] latch_ff, nxt_latch;
	logic [NCH-1:0] hit;
	logic [31:0] flash_cnt_ff, nxt_flash_cnt;
	logic flash_ff, nxt_flash;
	logic [NCH-1:0] led_ff, nxt_led;
	logic buz_ff, nxt_buz, err_ff, nxt_err, sum_led_ff, nxt_sum_led, cont_ff, nxt_cont;
	reset_btn_if rb ();

	// Compare one sample against ambient and the absolute limit
	function automatic logic over_limit(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] a);
		logic signed [TEMP_W:0] ts;
		logic signed [TEMP_W:0] as_;
		ts = {t[TEMP_W-1], t};
		as_ = {a[TEMP_W-1], a};
		over_limit = ((ts - as_) > RISE_LIMIT) || (ts > ABS_LIMIT); // RULE1 RULE2
	endfunction

	// Pin synchronisers; first stage is read only by the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			btn_m_ff <= 1'b0;
			btn_s_ff <= 1'b0;
			err_m_ff <= '0;
			err_s_ff <= '0;
		end else begin
			btn_m_ff <= reset_btn;
			btn_s_ff <= btn_m_ff;
			err_m_ff <= chain_err;
			err_s_ff <= err_m_ff;
		end
	end

	reset_btn_qual #(
		.HOLD_CYCLES(HOLD_CYCLES),
		.DEB_CYCLES(DEB_CYCLES)
	) u_btn (
		.clk(clk),
		.rst_b(rst_b),
		.btn_sync(btn_s_ff),
		.bus(rb.qual)
	);

	// Per-channel detection; samples are digital words with a present flag
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign hit[g] = probe_present[g] && // RULE8 RULE12
				over_limit(chan_temp[g*TEMP_W +: TEMP_W], amb_temp);
		end
	endgenerate

	// Latches: a new hit in the clear cycle wins and stays set
	always_comb begin
		nxt_latch = latch_ff;
		if (rb.clear_pulse) begin
			nxt_latch = '0; // RULE3
		end
		nxt_latch = nxt_latch | hit; // RULE3
	end

	// Free running flash divider for absent probes
	always_comb begin
		nxt_flash_cnt = flash_cnt_ff + 32'h1;
		nxt_flash = flash_ff;
		if (flash_cnt_ff >= 32'(FLASH_CYCLES - 1)) begin
			nxt_flash_cnt = '0;
			nxt_flash = !flash_ff;
		end
	end

	// Outputs; latched alarm outranks a since-removed probe
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			if (latch_ff[i]) begin
				nxt_led[i] = 1'b1; // RULE7
			end else if (!probe_present[i]) begin
				nxt_led[i] = flash_ff; // RULE7
			end else begin
				nxt_led[i] = 1'b0;
			end
		end
		nxt_buz = |latch_ff; // RULE5
		nxt_err = |latch_ff; // RULE4
		// Own alarm merged locally so a lone unit still closes the contact
		nxt_sum_led = (|err_s_ff) || (|latch_ff); // RULE6 RULE9
		nxt_cont = (|err_s_ff) || (|latch_ff); // RULE10 RULE4
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_ff <= '0;
			flash_cnt_ff <= 32'h0;
			flash_ff <= 1'b0;
			led_ff <= '0;
			buz_ff <= 1'b0;
			err_ff <= 1'b0;
			sum_led_ff <= 1'b0;
			cont_ff <= 1'b0;
		end else begin
			latch_ff <= nxt_latch;
			flash_cnt_ff <= nxt_flash_cnt;
			flash_ff <= nxt_flash;
			led_ff <= nxt_led;
			buz_ff <= nxt_buz;
			err_ff <= nxt_err;
			sum_led_ff <= nxt_sum_led;
			cont_ff <= nxt_cont;
		end
	end

	assign channel_indicators = led_ff;
	assign buzzer = buz_ff;
	assign err_out = err_ff;
	assign summary_overheat_indicator = sum_led_ff;
	assign summary_contact = cont_ff;
endmodule
`default_nettype wire

/* File: rtl/runaway_pkg.sv */
// Shared constants and types for the battery thermal runaway monitor
// How it works
// RULE1 - Flag a channel when its temperature exceeds ambient by over 40 C.
// RULE2 - Flag a channel when its absolute temperature exceeds 80 C.
// RULE3 - Alarms stay latched until reset button is held long then released.
// RULE4 - Any latched channel closes the summary alarm contact output.
// RULE5 - Buzzer sounds only on a unit with its own channel latched.
// RULE6 - Summary overheat indicator lights when any chained unit reports runaway.
// RULE7 - Channel indicator: off when fine, steady on when latched, flashing when absent.
// RULE8 - Absent probe channels are ignored; other channels keep working.
// RULE9 - Summary combines at most four chained units on one error line.
// RULE10 - Summary dry contact closes (normally open) when the error line is asserted.
// RULE11 - Reset button debounced; only a long enough hold then release clears.
// RULE12 - Temperatures arrive as digital samples with per-channel probe-present flags.
package runaway_pkg;
	localparam int TEMP_W = 12;              // Signed, 1/16 degree C per lsb
	localparam int TEMP_FRAC = 4;
	localparam int RISE_LIMIT_C = 40;
	localparam int ABS_LIMIT_C = 80;
	localparam logic signed [TEMP_W:0] RISE_LIMIT = 13'(RISE_LIMIT_C <<< TEMP_FRAC);
	localparam logic signed [TEMP_W:0] ABS_LIMIT = 13'(ABS_LIMIT_C <<< TEMP_FRAC);
	localparam int CLK_HZ = 25_000_000;
	localparam int HOLD_MS = 3000;           // Minimum reset hold time
	localparam int DEBOUNCE_MS = 20;
	localparam int FLASH_MS = 250;           // Half period of the absent-probe flash
	localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam int MAX_UNITS = 4;
	typedef enum logic [1:0] {
		BTN_IDLE,
		BTN_HELD,
		BTN_ARMED
	} btn_state_t;
endpackage

/* File: rtl/reset_btn_if.sv */
// Handshake between the top monitor and the reset button qualifier
`timescale 1ns/1ps
`default_nettype none
interface reset_btn_if;
	logic clear_pulse; // One-cycle latch clear
	logic pressed;     // Debounced button level
	modport qual (output clear_pulse, output pressed);
	modport mon (input clear_pulse, input pressed);
endinterface
`default_nettype wire

/* File: rtl/reset_btn_qual.sv */
// Debounce and long-hold qualifier for the latch reset button
`timescale 1ns/1ps
`default_nettype none
module reset_btn_qual
	import runaway_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
	input wire logic clk,       // 25 MHz clock
	input wire logic rst_b,     // Async reset, active low
	input wire logic btn_sync,  // Synchronised button, high when pressed
	reset_btn_if.qual bus       // Qualified outputs
);
	logic [31:0] deb_cnt_ff, nxt_deb_cnt;
	logic [31:0] hold_cnt_ff, nxt_hold_cnt;
	logic level_ff, nxt_level;
	logic clr_ff, nxt_clr;
	btn_state_t state_ff, nxt_state;

	// Debounce: level follows the input only after it is stable
	always_comb begin
		nxt_deb_cnt = deb_cnt_ff;
		nxt_level = level_ff;
		if (btn_sync == level_ff) begin
			nxt_deb_cnt = '0;
		end else if (deb_cnt_ff >= 32'(DEB_CYCLES - 1)) begin
			nxt_deb_cnt = '0;
			nxt_level = btn_sync;
		end else begin
			nxt_deb_cnt = deb_cnt_ff + 32'h1;
		end
	end

	// Hold timer; clear fires on release only after the full hold
	always_comb begin
		nxt_state = state_ff;
		nxt_hold_cnt = hold_cnt_ff;
		nxt_clr = 1'b0;
		case (state_ff)
			BTN_IDLE: begin
				nxt_hold_cnt = '0;
				if (level_ff) begin
					nxt_state = BTN_HELD;
				end
			end
			BTN_HELD: begin
				if (!level_ff) begin
					nxt_state = BTN_IDLE; // RULE11
				end else if (hold_cnt_ff >= 32'(HOLD_CYCLES - 1)) begin
					nxt_state = BTN_ARMED;
				end else begin
					nxt_hold_cnt = hold_cnt_ff + 32'h1;
				end
			end
			BTN_ARMED: begin
				if (!level_ff) begin
					nxt_clr = 1'b1; // RULE3
					nxt_state = BTN_IDLE;
				end
			end
			default: nxt_state = BTN_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			deb_cnt_ff <= 32'h0;
			hold_cnt_ff <= 32'h0;
			level_ff <= 1'b0;
			clr_ff <= 1'b0;
			state_ff <= BTN_IDLE;
		end else begin
			deb_cnt_ff <= nxt_deb_cnt;
			hold_cnt_ff <= nxt_hold_cnt;
			level_ff <= nxt_level;
			clr_ff <= nxt_clr;
			state_ff <= nxt_state;
		end
	end

	assign bus.clear_pulse = clr_ff;
	assign bus.pressed = level_ff;
endmodule
`default_nettype wire

/* File: verif/runaway_properties.sv */
// Port-level assertions for the runaway monitor
`timescale 1ns/1ps
`default_nettype none
module runaway_properties
	import runaway_pkg::*;
#(parameter int NCH = 5, parameter int HOLD_CYCLES = 50) (
	input wire logic clk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic [NCH*TEMP_W-1:0] chan_temp, // Samples
	input wire logic [TEMP_W-1:0] amb_temp, // Ambient
	input wire logic [NCH-1:0] probe_present, // Probes
	input wire logic reset_btn, // Button
	input wire logic [MAX_UNITS-1:0] chain_err, // Chain
	input wire logic [NCH-1:0] channel_indicators, // Lamps
	input wire logic buzzer, // Buzzer
	input wire logic err_out, // Error line
	input wire logic summary_overheat_indicator, // Summary lamp
	input wire logic summary_contact // Contact
);
	logic [NCH-1:0] hit;
	logic any_hit, long_ff, nxt_long;
	logic [7:0] press_ff, nxt_press;
	// Thirteen-bit signed compare, so the rise cannot wrap
	always_comb begin
		for (int g = 0; g < NCH; g++) begin
			hit[g] = probe_present[g] && ($signed(chan_temp[g*TEMP_W+:TEMP_W]) > ABS_LIMIT
				|| $signed(chan_temp[g*TEMP_W+:TEMP_W]) - $signed(amb_temp) > RISE_LIMIT);
		end
		any_hit = |hit;
		nxt_press = reset_btn ? press_ff + 8'h01 : 8'h00;
		// Forgotten once the alarm is gone, so each latch episode needs its own long press
		nxt_long = (long_ff || press_ff > 8'(HOLD_CYCLES)) && buzzer;
	end
	// Record of a long press during an alarm; a clear without one is a fault
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			press_ff <= 8'h00;
			long_ff <= 1'b0;
		end else begin
			press_ff <= nxt_press;
			long_ff <= nxt_long;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_hit_lights: assert property (hit[0] |-> ##2 channel_indicators[0])
		else $error("lamp missed a hit");
	chk_hit_alarms: assert property (any_hit |-> ##2 (buzzer && err_out))
		else $error("alarm missed a hit");
	chk_rise_cause: assert property ($rose(buzzer) |-> $past(any_hit, 2))
		else $error("alarm without a hit");
	chk_latch_holds: assert property ($fell(buzzer) |-> long_ff && !reset_btn)
		else $error("latch dropped early");
	chk_lamp_steady: assert property (probe_present[0] [*3] ##0
		(channel_indicators[0] && !long_ff) |=> channel_indicators[0]) else $error("lamp not steady");
	chk_chain_closes: assert property ((|chain_err) [*4] |=> summary_contact)
		else $error("contact missed chain");
	chk_chain_opens: assert property ((chain_err == 4'h0) [*4] ##0 !err_out |-> !summary_contact)
		else $error("contact stuck");
	chk_err_summary: assert property (err_out |-> summary_contact && summary_overheat_indicator)
		else $error("summary missed own alarm");
	chk_buzz_own: assert property (channel_indicators == '0 |-> !buzzer)
		else $error("buzzer without own lamp");
	cover property ($fell(buzzer));
	cover property (chain_err != 4'h0 && summary_contact && !buzzer);
	cover property (!probe_present[2] && channel_indicators[2]);
endmodule
`default_nettype wire

/* File: verif/probe_bank.sv */
// Far-side model: probe front end and the chained sensor units
`timescale 1ns/1ps
`default_nettype none
module probe_bank
	import runaway_pkg::*;
(
	output logic [5*TEMP_W-1:0] chan_temp, // Channel samples
	output logic [TEMP_W-1:0] amb_temp, // Ambient sample
	output logic [4:0] probe_present, // Probe flags
	output logic [MAX_UNITS-1:0] chain_err // Chained alarms
);
	// Quiet start: all probes at 25 C, no chained alarm
	initial begin
		chan_temp = {5{12'h190}};
		amb_temp = 12'h190;
		probe_present = 5'h1F;
		chain_err = 4'h0;
	end
	// Loads one digital sample with its probe-present flag
	task automatic set_ch(input int ch, input logic [TEMP_W-1:0] t, input logic p);
		chan_temp[ch*TEMP_W+:TEMP_W] = t;
		probe_present[ch] = p;
	endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the runaway monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
	import runaway_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic reset_btn = 1'b0;
	logic [5*TEMP_W-1:0] chan_temp;
	logic [TEMP_W-1:0] amb_temp;
	logic [4:0] probe_present, ind;
	logic [3:0] chain_err;
	logic buzzer, err_out, sum_led, contact;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	probe_bank pm (.chan_temp, .amb_temp, .probe_present, .chain_err);
	battery_thermal_runaway_monitor #(.HOLD_CYCLES(50), .DEB_CYCLES(4), .FLASH_CYCLES(8)) dut (
		.clk, .rst_b, .chan_temp, .amb_temp, .probe_present, .reset_btn, .chain_err,
		.channel_indicators(ind), .buzzer, .err_out, .summary_overheat_indicator(sum_led),
		.summary_contact(contact));
	always #20 clk = ~clk;
	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string m, input logic [4:0] got, input logic [4:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Press for n cycles, then leave room for the release debounce
	task automatic press(input int n);
		reset_btn = 1'b1;
		wait_n(n);
		reset_btn = 1'b0;
		wait_n(16);
	endtask
	// Absolute limit alone; latch outlives recovery and a short press
	task automatic t_abs();
		pm.amb_temp = 12'h3C0;
		pm.set_ch(0, 12'h500, 1'b1);
		wait_n(6);
		chk("at 80 C", ind, 5'h00);
		pm.set_ch(0, 12'h501, 1'b1);
		wait_n(3);
		chk("over 80 C", {ind[0], buzzer, err_out, contact, sum_led}, 5'h1F);
		pm.set_ch(0, 12'h190, 1'b1);
		press(20);
		chk("short press", ind, 5'h01);
		press(70);
		chk("long press", ind | {4'h0, buzzer}, 5'h00);
	endtask
	// Rise over ambient alone, at and just over the limit
	task automatic t_rise();
		pm.amb_temp = 12'h140;
		pm.set_ch(1, 12'h3C0, 1'b1);
		wait_n(6);
		chk("rise 40 C", ind, 5'h00);
		pm.set_ch(1, 12'h3C1, 1'b1);
		wait_n(3);
		chk("rise over", ind, 5'h02);
		pm.set_ch(1, 12'h190, 1'b1);
		press(70);
		chk("rise cleared", ind, 5'h00);
	endtask
	// A hot missing probe flashes and is ignored; a neighbour still alarms
	task automatic t_absent();
		logic [1:0] seen;
		seen = 2'b00;
		pm.set_ch(2, 12'h7FF, 1'b0);
		repeat (20) begin
			wait_n(1);
			seen |= {ind[2], ~ind[2]};
		end
		chk("absent", {seen, buzzer, ind[1:0]}, 5'h18);
		pm.set_ch(1, 12'h501, 1'b1);
		wait_n(3);
		chk("neighbour", {ind[1], buzzer, 3'h0}, 5'h18);
		pm.set_ch(1, 12'h190, 1'b1);
		pm.set_ch(2, 12'h190, 1'b1);
		press(70);
	endtask
	// Fourth chained unit alarms: summary follows, own buzzer quiet
	task automatic t_chain();
		pm.chain_err = 4'h8;
		wait_n(5);
		chk("chain on", {buzzer, err_out, contact, sum_led, ind[0]}, 5'h06);
		pm.chain_err = 4'h0;
		wait_n(5);
		chk("chain off", {contact, sum_led, 3'h0}, 5'h00);
	endtask
	initial begin
		wait_n(16);
		rst_b = 1'b1;
		wait_n(2);
		t_abs();
		t_rise();
		t_absent();
		t_chain();
		test_done();
	end
endmodule
bind battery_thermal_runaway_monitor runaway_properties #(.NCH(NCH), .HOLD_CYCLES(HOLD_CYCLES)) chk_i (
	.clk, .rst_b, .chan_temp, .amb_temp, .probe_present, .reset_btn, .chain_err,
	.channel_indicators, .buzzer, .err_out, .summary_overheat_indicator, .summary_contact);
`default_nettype wire
